// [src/fpp_pkg.sv]
/*
 * Package for the flash programmer port: command codes, status bit positions,
 * polling encodings, bus strobe groups and timing constants.
 * Assumes a single 250 MHz clock domain and synchronous pin sampling.
 */
package fpp_pkg;

    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned ADDR_W       = 19;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned PAGE_BYTES   = 128;
    localparam int unsigned PAGE_LSB_W   = 7;

    // command codes and the erased byte value
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_PROG      = 8'h40;
    localparam logic [7:0] CMD_ERASE     = 8'h20;
    localparam logic [7:0] CMD_STATUS    = 8'h71;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    // status read byte bit positions
    localparam int unsigned ST_ABNORMAL  = 7;
    localparam int unsigned ST_CMD_ERR   = 6;
    localparam int unsigned ST_PROG_ERR  = 5;
    localparam int unsigned ST_ERASE_ERR = 4;
    localparam int unsigned ST_COUNT_ERR = 1;
    localparam int unsigned ST_ADDR_ERR  = 0;

    // polling encodings on the two top data lines
    localparam logic [7:0] POLL_BUSY     = 8'h00;
    localparam logic [7:0] POLL_ABNORMAL = 8'h80;
    localparam logic [7:0] POLL_NORMAL   = 8'hC0;

    // default array operation times, in microseconds and in clock cycles
    localparam int unsigned PROG_TIME_US  = 1000;
    localparam int unsigned ERASE_TIME_US = 100000;
    localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;

    // mode of the command interpreter
    typedef enum logic [2:0] {
        M_CMD_WAIT,
        M_READ,
        M_PROG_LOAD,
        M_PROG_BUSY,
        M_ERASE_ARM,
        M_ERASE_BUSY,
        M_STATUS_ARM,
        M_STATUS
    } mode_t;

    // active-low strobes from the programmer
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } strobe_t;

    // one byte bound for the flash array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } prog_word_t;

endpackage : fpp_pkg

// [src/fpp_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fpp_fifo #(
    parameter int unsigned WIDTH = 27,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             srst_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    // handshake flags
    assign in_ready_out  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (s_q.cnt != '0);
    assign out_data_out  = s_q.mem[s_q.rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // next state
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data_in;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop)
        begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : fpp_fifo

// [src/flash_programmer_port.sv]
/*
 * Byte-wide programmer port: strobe decode, command interpreter, page
 * collection through a FIFO toward the array, status polling and status read.
 * Assumes pins already synchronous to sys_clk_in; the flash array sits
 * outside and returns error flags, sampled once the internal operation timer has expired and the FIFO has drained.
 */
`timescale 1ns/1ps
// Function
// (RULE1) programmer straps mode, strap and standby inputs before entering this mode
// (RULE2) strobes decode into read, output disable and command write cycles
// (RULE3) chip-select high floats data but operations keep running
// (RULE4) command 00 selects memory read; reads then return addressed byte
// (RULE5) auto-program is command 40 then 128 data writes, 129 total
// (RULE6) two writes of 20 erase the whole array; completion by polling
// (RULE7) two writes of 71 select status read of last operation result
// (RULE8) program, erase or status end in command wait; reads need read command
// (RULE9) memory read mode accepts commands like command wait
// (RULE10) consecutive reads allowed in memory read mode
// (RULE11) after reset the port starts in memory read mode
// (RULE12) one page of 128 bytes is programmed per operation
// (RULE13) programmer pads unused page bytes with FF
// (RULE14) nonzero low 7 page address bits start programming yet flag error
// (RULE15) page address is captured on the second program cycle
// (RULE16) no command writes while programming is in progress
// (RULE17) each page programmed once; erase before reprogramming
// (RULE18) line 7 marks end, line 6 marks normal end
// (RULE19) polling flags held until next command write, driven on reads
// (RULE20) program, erase and status use polling; status read gives detail
// (RULE21) polling: busy 00, abnormal 80, normal C0, low lines zero
// (RULE22) status byte bits: 7 abnormal, 6 command, 5 program, 4 erase, 1 count, 0 address
// (RULE23) status code held until a non-status command write
// (RULE24) no command writes while erasing is in progress
// (RULE25) data lines driven only in read cycles, else released
module flash_programmer_port #(
    parameter int unsigned ADDR_W      = fpp_pkg::ADDR_W,
    parameter int unsigned FIFO_DEPTH  = 16,
    parameter int unsigned PROG_CYCLES = fpp_pkg::PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = fpp_pkg::ERASE_CYCLES
) (
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 srst_in,

    // mode straps
    input  wire logic [2:0]           mode_select_inputs_in,
    input  wire logic                 strap_a_in,
    input  wire logic                 strap_b_in,
    input  wire logic                 strap_c_in,
    input  wire logic                 strap_d_in,
    input  wire logic                 strap_e_in,
    input  wire logic                 hw_standby_input_n_in,

    // programmer bus
    input  wire logic                 ce_n_in,
    input  wire logic                 oe_n_in,
    input  wire logic                 we_n_in,
    input  wire logic [ADDR_W-1:0]    address_lines_in,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic                      data_oe_out,

    // array read port
    output logic      [ADDR_W-1:0]    array_rd_addr_out,
    input  wire logic [7:0]           array_rd_data_in,

    // array program stream
    output logic                      prog_valid_out,
    input  wire logic                 prog_ready_in,
    output logic      [ADDR_W+7:0]    prog_word_out,

    // array operation control and result
    output logic                      array_erase_out,
    input  wire logic                 array_prog_err_in,
    input  wire logic                 array_erase_err_in,
    input  wire logic                 array_count_err_in,

    // status
    output logic                      programmer_mode_out,
    output logic                      busy_out
);
    typedef struct packed {
        fpp_pkg::mode_t    mode;
        logic              we_n_prev;
        logic [7:0]        page_cnt;
        logic [ADDR_W-1:0] page_addr;
        logic [31:0]       timer;
        logic              poll_valid;
        logic [7:0]        poll;
        logic [7:0]        status;
        logic [7:0]        dout;
        logic              dout_en;
        logic              erase;
    } port_state_t;

    port_state_t         s_q;
    port_state_t         s_d;

    fpp_pkg::strobe_t    stb;
    fpp_pkg::prog_word_t wr_word;
    logic                strap_ok;
    logic                rd_cycle;
    logic                wr_edge;
    logic                fifo_valid;
    logic                fifo_ready;
    logic                fifo_empty;

    assign stb.ce_n = ce_n_in;
    assign stb.oe_n = oe_n_in;
    assign stb.we_n = we_n_in;

    // strap check for programmer mode entry  [RULE1]
    assign strap_ok = (mode_select_inputs_in == 3'h0) && strap_a_in && !strap_b_in
                      && !strap_c_in && strap_d_in && !strap_e_in && hw_standby_input_n_in;

    // cycle decode: read, and write taken on the rising edge of the write strobe  [RULE2]
    assign rd_cycle = strap_ok && !stb.ce_n && !stb.oe_n && stb.we_n;
    assign wr_edge  = strap_ok && !stb.ce_n && stb.oe_n && stb.we_n && !s_q.we_n_prev;

    // bytes pushed toward the array carry page address plus byte offset  [RULE15]
    assign wr_word.addr = {(s_q.page_cnt == '0) ? address_lines_in[ADDR_W-1:fpp_pkg::PAGE_LSB_W]
                           : s_q.page_addr[ADDR_W-1:fpp_pkg::PAGE_LSB_W],
                           address_lines_in[fpp_pkg::PAGE_LSB_W-1:0]};
    assign wr_word.data = data_in;
    assign fifo_valid   = wr_edge && (s_q.mode == fpp_pkg::M_PROG_LOAD);

    assign array_rd_addr_out   = address_lines_in;
    assign array_erase_out     = s_q.erase;
    assign programmer_mode_out = strap_ok;
    assign busy_out            = (s_q.mode == fpp_pkg::M_PROG_BUSY)
                                 || (s_q.mode == fpp_pkg::M_ERASE_BUSY);
    assign data_out            = s_q.dout;
    assign data_oe_out         = s_q.dout_en;
    assign fifo_empty          = !prog_valid_out;

    // page bytes queue here; array back-pressure stalls the drain side  [RULE12]
    fpp_fifo #(
        .WIDTH ($bits(fpp_pkg::prog_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (fifo_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (wr_word),
        .out_valid_out (prog_valid_out),
        .out_ready_in  (prog_ready_in),
        .out_data_out  (prog_word_out)
    );

    // command interpreter and output data
    always_comb
    begin
        s_d           = s_q;
        s_d.we_n_prev = stb.we_n;
        s_d.erase     = 1'b0;

        if (s_q.timer != '0)
        begin
            s_d.timer = s_q.timer - 32'h1;
        end

        case (s_q.mode)
            fpp_pkg::M_CMD_WAIT, fpp_pkg::M_READ, fpp_pkg::M_STATUS:
            begin
                // command accepted in wait, read and status alike  [RULE9]
                if (wr_edge)
                begin
                    s_d.poll_valid = 1'b0; // polling flags end at next command  [RULE19]
                    if (data_in != fpp_pkg::CMD_STATUS)
                    begin
                        s_d.status = '0; // status code kept until other command  [RULE23]
                    end

                    case (data_in)
                        fpp_pkg::CMD_READ:   s_d.mode = fpp_pkg::M_READ; // [RULE4]
                        fpp_pkg::CMD_PROG:
                        begin
                            s_d.mode     = fpp_pkg::M_PROG_LOAD; // [RULE5]
                            s_d.page_cnt = '0;
                        end
                        fpp_pkg::CMD_ERASE:  s_d.mode = fpp_pkg::M_ERASE_ARM; // [RULE6]
                        fpp_pkg::CMD_STATUS: s_d.mode = fpp_pkg::M_STATUS_ARM; // [RULE7]
                        default:
                        begin
                            s_d.mode = fpp_pkg::M_CMD_WAIT;
                            s_d.status[fpp_pkg::ST_CMD_ERR]  = 1'b1;
                            s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                        end
                    endcase
                end
            end

            fpp_pkg::M_PROG_LOAD:
            begin
                if (wr_edge)
                begin
                    if (s_q.page_cnt == 8'h00)
                    begin
                        // page address taken on the second cycle only  [RULE15]
                        s_d.page_addr = address_lines_in;
                        if (address_lines_in[fpp_pkg::PAGE_LSB_W-1:0] != '0)
                        begin
                            s_d.status[fpp_pkg::ST_ADDR_ERR] = 1'b1; // [RULE14]
                            s_d.status[fpp_pkg::ST_PROG_ERR] = 1'b1;
                            s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                        end
                    end

                    if (!fifo_ready)
                    begin
                        // programmer outran the array: byte lost
                        s_d.status[fpp_pkg::ST_PROG_ERR] = 1'b1;
                        s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                    end

                    s_d.page_cnt = s_q.page_cnt + 8'h01;
                    if (s_q.page_cnt == 8'(fpp_pkg::PAGE_BYTES - 1))
                    begin
                        // full page collected: programming starts  [RULE12]
                        s_d.mode  = fpp_pkg::M_PROG_BUSY;
                        s_d.timer = 32'(PROG_CYCLES);
                        s_d.poll       = fpp_pkg::POLL_BUSY;
                        s_d.poll_valid = 1'b1;
                    end
                end
            end

            fpp_pkg::M_PROG_BUSY, fpp_pkg::M_ERASE_BUSY:
            begin
                // writes here are ignored; programmer must not send them  [RULE16] [RULE24]
                if (s_q.timer == '0 && fifo_empty)
                begin
                    if (array_prog_err_in && s_q.mode == fpp_pkg::M_PROG_BUSY)
                    begin
                        s_d.status[fpp_pkg::ST_PROG_ERR] = 1'b1;
                    end
                    if (array_erase_err_in && s_q.mode == fpp_pkg::M_ERASE_BUSY)
                    begin
                        s_d.status[fpp_pkg::ST_ERASE_ERR] = 1'b1;
                    end
                    if (array_count_err_in)
                    begin
                        s_d.status[fpp_pkg::ST_COUNT_ERR] = 1'b1;
                    end

                    // end-of-operation polling code  [RULE18] [RULE21]
                    if (s_d.status[5:0] != '0)
                    begin
                        s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                        s_d.poll = fpp_pkg::POLL_ABNORMAL;
                    end
                    else
                    begin
                        s_d.poll = fpp_pkg::POLL_NORMAL;
                    end

                    s_d.mode = fpp_pkg::M_CMD_WAIT; // [RULE8]
                end
            end

            fpp_pkg::M_ERASE_ARM:
            begin
                if (wr_edge)
                begin
                    if (data_in == fpp_pkg::CMD_ERASE)
                    begin
                        // whole-array erase starts  [RULE6]
                        s_d.mode       = fpp_pkg::M_ERASE_BUSY;
                        s_d.erase      = 1'b1;
                        s_d.timer      = 32'(ERASE_CYCLES);
                        s_d.poll       = fpp_pkg::POLL_BUSY;
                        s_d.poll_valid = 1'b1;
                    end
                    else
                    begin
                        s_d.mode = fpp_pkg::M_CMD_WAIT;
                        s_d.status[fpp_pkg::ST_CMD_ERR]  = 1'b1;
                        s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                    end
                end
            end

            fpp_pkg::M_STATUS_ARM:
            begin
                if (wr_edge)
                begin
                    if (data_in == fpp_pkg::CMD_STATUS)
                    begin
                        s_d.mode = fpp_pkg::M_STATUS; // [RULE7] [RULE20]
                    end
                    else
                    begin
                        s_d.mode = fpp_pkg::M_CMD_WAIT;
                        s_d.status[fpp_pkg::ST_CMD_ERR]  = 1'b1;
                        s_d.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                    end
                end
            end

            default:
            begin
                s_d.mode = fpp_pkg::M_CMD_WAIT;
            end
        endcase

        // read data select; bus released outside read cycles  [RULE3] [RULE25]
        s_d.dout_en = rd_cycle;

        if (s_q.mode == fpp_pkg::M_STATUS)
        begin
            s_d.dout = s_q.status & 8'hF3; // detailed status byte  [RULE22]
        end
        else if (s_q.poll_valid)
        begin
            s_d.dout = s_q.poll; // polling flags on the top lines  [RULE19] [RULE20]
        end
        else if (s_q.mode == fpp_pkg::M_READ)
        begin
            s_d.dout = array_rd_data_in; // any number of reads  [RULE10]
        end
        else
        begin
            s_d.dout = '0;
        end
    end

    // state register; reset lands in memory read mode  [RULE11]
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            s_q           <= '0;
            s_q.mode      <= fpp_pkg::M_READ;
            s_q.we_n_prev <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : flash_programmer_port

// [dv/flash_programmer_port_monitor.sv]
/*
 * Assertion checker for the flash programmer port, bound to its top module.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module flash_programmer_port_monitor #(
    parameter int unsigned ADDR_W = 19
) (
    // clock, reset and straps
    input wire logic              sys_clk_in,
    input wire logic              srst_in,
    input wire logic [2:0]        mode_select_inputs_in,
    input wire logic              strap_a_in,
    input wire logic              strap_b_in,
    input wire logic              strap_c_in,
    input wire logic              strap_d_in,
    input wire logic              strap_e_in,
    input wire logic              hw_standby_input_n_in,
    // programmer bus
    input wire logic              ce_n_in,
    input wire logic              oe_n_in,
    input wire logic              we_n_in,
    input wire logic [ADDR_W-1:0] address_lines_in,
    input wire logic [7:0]        data_in,
    input wire logic [7:0]        data_out,
    input wire logic              data_oe_out,
    // array side and status
    input wire logic [ADDR_W-1:0] array_rd_addr_out,
    input wire logic              prog_valid_out,
    input wire logic              prog_ready_in,
    input wire logic [ADDR_W+7:0] prog_word_out,
    input wire logic              array_erase_out,
    input wire logic              programmer_mode_out,
    input wire logic              busy_out
);
    logic rd_cyc;

    default clocking mon_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    // read cycle decode of the strobes
    assign rd_cyc = !ce_n_in && !oe_n_in && we_n_in;

    // bus, polling, erase, stream and strap decode checks
    a_oe_read_only: assert property (data_oe_out |-> $past(rd_cyc))
        else $error("data lines driven outside a read cycle");
    a_read_drives: assert property (rd_cyc && programmer_mode_out |=> data_oe_out)
        else $error("read cycle not answered");
    a_poll_busy: assert property (busy_out && $past(busy_out) && data_oe_out |-> data_out == 8'h00)
        else $error("busy poll byte not zero");
    a_erase_pulse: assert property (array_erase_out |-> busy_out ##1 (busy_out && !array_erase_out) [*7])
        else $error("erase start not a single pulse with busy");
    a_erase_cause: assert property (array_erase_out |-> $past(data_in) == 8'h20 && !$past(we_n_in, 2))
        else $error("erase started without erase command");
    a_stream_hold: assert property (prog_valid_out && !prog_ready_in |=> prog_valid_out && $stable(prog_word_out))
        else $error("program word dropped while stalled");
    a_strap_decode: assert property (programmer_mode_out == (mode_select_inputs_in == 3'h0 && strap_a_in && !strap_b_in && !strap_c_in && strap_d_in && !strap_e_in && hw_standby_input_n_in))
        else $error("programmer mode decode wrong");
    a_rd_addr: assert property (array_rd_addr_out == address_lines_in)
        else $error("array read address differs from bus");
endmodule : flash_programmer_port_monitor

bind flash_programmer_port flash_programmer_port_monitor #(.ADDR_W(ADDR_W)) mon (
    .sys_clk_in, .srst_in, .mode_select_inputs_in, .strap_a_in, .strap_b_in, .strap_c_in,
    .strap_d_in, .strap_e_in, .hw_standby_input_n_in, .ce_n_in, .oe_n_in, .we_n_in,
    .address_lines_in, .data_in, .data_out, .data_oe_out, .array_rd_addr_out, .prog_valid_out,
    .prog_ready_in, .prog_word_out, .array_erase_out, .programmer_mode_out, .busy_out);

// [dv/flash_array_model.sv]
/*
 * Behavioural flash array on the far side of the programmer port.
 * Assumes one clock, synchronous active-high reset and a bench-set stall.
 */
`timescale 1ns/1ps
module flash_array_model #(
    parameter int unsigned ADDR_W = 19
) (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              srst_in,
    // read port and program stream
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [7:0]        rd_data_out,
    input  wire logic              prog_valid_in,
    output logic                   prog_ready_out,
    input  wire logic [ADDR_W+7:0] prog_word_in,
    // bench control and observation
    input  wire logic              slow_in,
    output logic      [7:0]        taken_out
);
    logic phase_q;

    // contents are a fixed pattern of the address
    assign rd_data_out = rd_addr_in[7:0] ^ 8'hA5;
    // slow mode takes a byte only every other cycle
    assign prog_ready_out = !slow_in || phase_q;

    // count bytes accepted from the stream
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            phase_q <= 1'b0;
            taken_out <= 8'h00;
        end
        else
        begin
            phase_q <= !phase_q;
            if (prog_valid_in && prog_ready_out && prog_word_in[0] !== 1'bx)
                taken_out <= taken_out + 8'h01;
        end
    end
endmodule : flash_array_model

// [dv/flash_programmer_port_tb_top.sv]
/*
 * Self-checking bench for the flash programmer port with an array model.
 * Assumes shortened program and erase times; inputs change on falling edges.
 */
`timescale 1ns/1ps
module flash_programmer_port_tb_top;
    localparam int AW = 19;
    logic          sys_clk_in = 1'b0;
    logic          srst_in = 1'b1;
    logic          ce_n = 1'b0;
    logic          oe_n = 1'b1;
    logic          we_n = 1'b1;
    logic          slow = 1'b0;
    logic [8:0]    pins = 9'h025;
    logic [2:0]    aerr = 3'h0;
    logic [AW-1:0] addr = 19'h00000;
    logic [7:0]    wdata = 8'h00;
    logic [7:0]    data_out, rd_data, taken;
    logic [AW-1:0] rd_addr;
    logic [AW+7:0] pword;
    logic          data_oe_out, pvalid, pready, busy_out, pmode;
    int            err_total = 0;
    int            check_count = 0;

    // 250 MHz clock
    always #2 sys_clk_in = ~sys_clk_in;

    // device under test with short array times, straps set for programmer mode
    flash_programmer_port #(.PROG_CYCLES(50), .ERASE_CYCLES(60)) uut (
        .sys_clk_in, .srst_in, .mode_select_inputs_in(pins[8:6]),
        .strap_a_in(pins[5]), .strap_b_in(pins[4]), .strap_c_in(pins[3]), .strap_d_in(pins[2]),
        .strap_e_in(pins[1]), .hw_standby_input_n_in(pins[0]), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .address_lines_in(addr), .data_in(wdata), .data_out(data_out),
        .data_oe_out(data_oe_out), .array_rd_addr_out(rd_addr), .array_rd_data_in(rd_data),
        .prog_valid_out(pvalid), .prog_ready_in(pready), .prog_word_out(pword),
        .array_erase_out(), .array_prog_err_in(aerr[2]), .array_erase_err_in(aerr[1]),
        .array_count_err_in(aerr[0]), .programmer_mode_out(pmode), .busy_out);

    flash_array_model #(.ADDR_W(AW)) array_model (
        .sys_clk_in, .srst_in, .rd_addr_in(rd_addr),
        .rd_data_out(rd_data), .prog_valid_in(pvalid), .prog_ready_out(pready),
        .prog_word_in(pword), .slow_in(slow), .taken_out(taken));

    function automatic logic [7:0] mem_byte(input logic [AW-1:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction : mem_byte

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk8

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // command write: strobe low one cycle, data held past the rising edge
    task automatic wr(input logic [7:0] d);
        @(negedge sys_clk_in);
        oe_n = 1'b1;
        we_n = 1'b0;
        wdata = d;
        @(negedge sys_clk_in);
        we_n = 1'b1;
        @(negedge sys_clk_in);
    endtask : wr

    // read cycle: output enable stays low for back-to-back reads
    task automatic rd(input logic [AW-1:0] a, input logic [7:0] exp);
        @(negedge sys_clk_in);
        addr = a;
        oe_n = 1'b0;
        @(negedge sys_clk_in);
        chk8({7'h00, data_oe_out}, 8'h01);
        chk8(data_out, exp);
    endtask : rd

    task automatic wait_idle();
        for (int i = 0; i < 4000 && busy_out !== 1'b0; i++)
            @(negedge sys_clk_in);
        chk8({7'h00, busy_out}, 8'h00);
    endtask : wait_idle

    task automatic t_reset_read();
        rd(19'h00012, mem_byte(19'h00012));
        rd(19'h7FFFF, mem_byte(19'h7FFFF));
        @(negedge sys_clk_in);
        ce_n = 1'b1;
        pins[0] = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk8({7'h00, data_oe_out}, 8'h00);
        chk8({7'h00, pmode}, 8'h00);
        ce_n = 1'b0;
        pins[0] = 1'b1;
    endtask : t_reset_read

    task automatic t_page(input logic [AW-1:0] base, input logic slw, input logic [7:0] poll,
                          input logic [7:0] stat);
        logic [7:0] n0;
        n0 = taken;
        slow = slw;
        wr(fpp_pkg::CMD_PROG);
        for (int i = 0; i < 128; i++)
        begin
            addr = base + AW'(i);
            wr((i == 127) ? fpp_pkg::ERASED_BYTE : 8'(i));
        end
        repeat (2) @(negedge sys_clk_in);
        chk8({7'h00, busy_out}, 8'h01);
        rd(base, fpp_pkg::POLL_BUSY);
        wait_idle();
        chk8(taken - n0, 8'h80);
        rd(base, poll);
        rd(base, poll);
        wr(fpp_pkg::CMD_STATUS);
        wr(fpp_pkg::CMD_STATUS);
        rd(base, stat);
        rd(base, stat);
        slow = 1'b0;
    endtask : t_page

    task automatic t_erase();
        wr(fpp_pkg::CMD_ERASE);
        wr(fpp_pkg::CMD_ERASE);
        repeat (2) @(negedge sys_clk_in);
        chk8({7'h00, busy_out}, 8'h01);
        rd(19'h00010, fpp_pkg::POLL_BUSY);
        wait_idle();
        rd(19'h00010, fpp_pkg::POLL_NORMAL);
        wr(fpp_pkg::CMD_READ);
        rd(19'h00010, mem_byte(19'h00010));
    endtask : t_erase

    task automatic t_bad_cmd();
        wr(8'h33);
        wr(fpp_pkg::CMD_STATUS);
        wr(fpp_pkg::CMD_STATUS);
        rd(19'h00000, 8'hC0);
        wr(fpp_pkg::CMD_READ);
        rd(19'h00044, mem_byte(19'h00044));
    endtask : t_bad_cmd

    // main sequence
    initial
    begin
        repeat (10) @(negedge sys_clk_in);
        srst_in = 1'b0;
        t_reset_read();
        t_page(19'h00100, 1'b1, fpp_pkg::POLL_NORMAL, 8'h00);
        t_erase();
        aerr = 3'h7;
        t_page(19'h00205, 1'b0, fpp_pkg::POLL_ABNORMAL, 8'hA3);
        t_bad_cmd();
        print_verdict();
    end

    // watchdog well beyond the expected thousand or so cycles
    initial
    begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule : flash_programmer_port_tb_top
